// ==== verilog/tbeic_cfg.svh ====
// Offsets, field positions, reset values and command codes of the timer control block
// Assumes an 8-bit register port with a 6-bit byte address
`ifndef TBEIC_CFG_SVH
`define TBEIC_CFG_SVH

// ***********************************************
// Register offsets
// ***********************************************
`define TBEIC_A_CTRL_CLR 6'h04
`define TBEIC_A_CTRL_SET 6'h05
`define TBEIC_A_BV_CLR 6'h06
`define TBEIC_A_BV_SET 6'h07
`define TBEIC_A_EVCTL 6'h09
`define TBEIC_A_IEN 6'h0a
`define TBEIC_A_IFLAG 6'h0b
`define TBEIC_A_DBG 6'h0e
`define TBEIC_A_TEMP 6'h0f
`define TBEIC_A_CNT 6'h20
`define TBEIC_A_PER 6'h26
`define TBEIC_A_CMP 6'h28
`define TBEIC_A_PERBUF 6'h36
`define TBEIC_A_CMPBUF 6'h38

// ***********************************************
// Field positions
// ***********************************************
`define TBEIC_B_DIR 0
`define TBEIC_B_LOCK 1
`define TBEIC_B_CMD 2
`define TBEIC_B_EV_EN 0
`define TBEIC_B_EV_ACT 1
`define TBEIC_B_WRAP 0
`define TBEIC_B_CMPF 4
`define TBEIC_B_DBG_RUN 0

// ***********************************************
// Reset values and commands
// ***********************************************
`define TBEIC_RST_PER 16'hffff
`define TBEIC_RST_WORD 16'h0000
`define TBEIC_RST_BYTE 8'h00
`define TBEIC_CMD_UPDATE 2'h1

`endif

// ==== verilog/tbeic_pkg.sv ====
// Types shared by the timer control block
// Assumes the constants header is included where offsets are needed
package tbeic_pkg;

   typedef enum logic [1:0] {
      ev_rising_count = 2'b00,
      ev_edge_count = 2'b01,
      ev_level_gate = 2'b10,
      ev_direction_control = 2'b11
   } tbeic_event_action_t;

   typedef enum logic [2:0] {
      wg_normal = 3'b000,
      wg_frequency = 3'b001,
      wg_rsv2 = 3'b010,
      wg_single_slope = 3'b011,
      wg_rsv4 = 3'b100,
      wg_dual_top = 3'b101,
      wg_dual_both = 3'b110,
      wg_dual_bottom = 3'b111
   } tbeic_wave_t;

   // One register port access
   typedef struct packed {
      logic wr;
      logic rd;
      logic [5:0] addr;
      logic [7:0] wdata;
   } tbeic_bus_t;

   // Whole state of the block
   typedef struct packed {
      logic [15:0] cnt;
      logic [15:0] per;
      logic [15:0] per_staging;
      logic [2:0][15:0] cmp;
      logic [2:0][15:0] cmp_staging;
      logic [3:0] buffer_valid;
      logic update_lock;
      logic dir;
      tbeic_event_action_t event_action;
      logic event_count_enable;
      logic [3:0] irq_enable;
      logic [3:0] irq_flag;
      logic run_when_halted;
      logic [7:0] temp;
      logic event_prev;
      logic [7:0] rdata;
   } tbeic_state_t;

endpackage : tbeic_pkg

// ==== verilog/tbeic_timer_ctrl.sv ====
// Control, buffering, event counting and flag logic of a 16-bit timer/counter
// Assumes all inputs are synchronous to clk (event system, prescaler and debug logic on the same clock)
`timescale 1ns/1ps
`include "tbeic_cfg.svh"

// What this block does
// - Lock bit blocks buffer transfer on update
// - Direction bit: 0 counts up, 1 down
// - Hardware and software both drive direction
// - Write one to clear buffer-valid flags
// - Write one to set; both addresses read flags
// - Compare buffer write sets flag, update clears
// - Period buffer write sets flag, update clears
// - Event action 0 rising, 1 any edge
// - Action 2 counts ticks while event high
// - Action 3 ticks, event selects direction
// - Event count enable gates event counting
// - Compare interrupt enables at bits 4-6
// - Wrap interrupt enable at bit 0
// - Compare flag set on counter match
// - Compare flags cleared only by software
// - Wrap flag set per mode, software clears
// - Halt in debug break; events ignored except action 3 direction
// - One shared temp byte, software accessible
// - Counter low byte base, high plus one
// - Bus write to counter beats counting
// - Update loads compares unless locked
// - Period buffer stages period, sets valid
module tbeic_timer_ctrl
   import tbeic_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire tbeic_bus_t bus,
   output logic [7:0] reg_rdata,
   input wire logic [2:0] waveform_select,
   input wire logic timer_enable,
   input wire logic prescale_tick,
   input wire logic event_in,
   input wire logic debug_break,
   output logic [2:0] compare_irq,
   output logic wrap_irq,
   output logic [15:0] counter_value,
   output logic count_down
);

   // ***********************************************
   // Word addresses of the wide registers
   // ***********************************************
   localparam logic [4:0] word_cnt = 5'(`TBEIC_A_CNT >> 1);
   localparam logic [4:0] word_per = 5'(`TBEIC_A_PER >> 1);
   localparam logic [4:0] word_cmp = 5'(`TBEIC_A_CMP >> 1);
   localparam logic [4:0] word_perbuf = 5'(`TBEIC_A_PERBUF >> 1);
   localparam logic [4:0] word_cmpbuf = 5'(`TBEIC_A_CMPBUF >> 1);

   // ***********************************************
   // State
   // ***********************************************
   tbeic_state_t s;
   tbeic_state_t next_s;
   tbeic_wave_t wave;
   logic halted;
   logic ev_step;
   logic step;
   logic down;
   logic [15:0] top_val;
   logic at_top;
   logic at_bot;
   logic dual;
   logic hit_top;
   logic hit_bot;
   logic upd;
   logic force_upd;
   logic ctrl_wr;
   logic xfer;
   logic wrap_pass;
   logic [3:0] wsel;
   logic wide;
   logic [15:0] wval;
   logic [15:0] wnew;

   assign wave = tbeic_wave_t'(waveform_select);

   // ***********************************************
   // Wide register decode
   // ***********************************************
   // 0 counter, 1 period, 2-4 compares, 5 period staging, 6-8 compare staging
   always_comb begin
      wsel = 4'h0;
      wide = 1'b1;
      case (bus.addr[5:1])
         word_cnt: wsel = 4'h0;
         word_per: wsel = 4'h1;
         word_cmp: wsel = 4'h2;
         word_cmp + 5'h1: wsel = 4'h3;
         word_cmp + 5'h2: wsel = 4'h4;
         word_perbuf: wsel = 4'h5;
         word_cmpbuf: wsel = 4'h6;
         word_cmpbuf + 5'h1: wsel = 4'h7;
         word_cmpbuf + 5'h2: wsel = 4'h8;
         default: wide = 1'b0;
      endcase
   end

   always_comb begin
      case (wsel)
         4'h0: wval = s.cnt;
         4'h1: wval = s.per;
         4'h2: wval = s.cmp[0];
         4'h3: wval = s.cmp[1];
         4'h4: wval = s.cmp[2];
         4'h5: wval = s.per_staging;
         4'h6: wval = s.cmp_staging[0];
         4'h7: wval = s.cmp_staging[1];
         4'h8: wval = s.cmp_staging[2];
         default: wval = `TBEIC_RST_WORD;
      endcase
   end

   // High byte from the bus, low byte from the shared temp
   assign wnew = {bus.wdata, s.temp};

   // ***********************************************
   // Counting source
   // ***********************************************
   always_comb begin
      // Events seen while halted are dropped, not queued
      halted = debug_break & ~s.run_when_halted;
      case (s.event_action)
         ev_rising_count: ev_step = event_in & ~s.event_prev;
         ev_edge_count: ev_step = event_in ^ s.event_prev;
         ev_level_gate: ev_step = prescale_tick & event_in;
         ev_direction_control: ev_step = prescale_tick;
         default: ev_step = 1'b0;
      endcase
      step = timer_enable & ~halted & (s.event_count_enable ? ev_step : prescale_tick);
      if (s.event_count_enable && s.event_action == ev_direction_control) begin
         down = event_in;
      end else begin
         down = s.dir;
      end
   end

   // ***********************************************
   // Update and wrap conditions
   // ***********************************************
   always_comb begin
      top_val = (wave == wg_frequency) ? s.cmp[0] : s.per;
      at_top = ~down & (s.cnt == top_val);
      at_bot = down & (s.cnt == `TBEIC_RST_WORD);
      // Reserved codes fall in with the family of their upper bit
      dual = waveform_select[2];
      // A single-slope wrap passes top and bottom in the same step
      wrap_pass = step & ~dual & (at_top | at_bot);
      hit_top = (step & at_top) | wrap_pass;
      hit_bot = (step & at_bot) | wrap_pass;
      case (wave)
         wg_normal, wg_frequency: upd = hit_top | hit_bot;
         default: upd = hit_bot;
      endcase
      ctrl_wr = bus.wr & ((bus.addr == `TBEIC_A_CTRL_CLR) | (bus.addr == `TBEIC_A_CTRL_SET));
      force_upd = ctrl_wr & (bus.wdata[`TBEIC_B_CMD +: 2] == `TBEIC_CMD_UPDATE);
      // Lock holds back both the copy and the valid-flag clear
      xfer = (upd | force_upd) & ~s.update_lock;
   end

   // ***********************************************
   // Next state
   // ***********************************************
   always_comb begin
      next_s = s;
      // Edge history follows the line even while halted
      next_s.event_prev = event_in;

      // Counter and hardware direction
      if (s.event_count_enable && s.event_action == ev_direction_control) begin
         next_s.dir = event_in;
      end
      if (step) begin
         if (dual) begin
            if (at_top) begin
               next_s.cnt = s.cnt - 16'h0001;
               next_s.dir = 1'b1;
            end else if (at_bot) begin
               next_s.cnt = s.cnt + 16'h0001;
               next_s.dir = 1'b0;
            end else if (down) begin
               next_s.cnt = s.cnt - 16'h0001;
            end else begin
               next_s.cnt = s.cnt + 16'h0001;
            end
         end else begin
            if (at_top) begin
               next_s.cnt = `TBEIC_RST_WORD;
            end else if (at_bot) begin
               next_s.cnt = top_val;
            end else if (down) begin
               next_s.cnt = s.cnt - 16'h0001;
            end else begin
               next_s.cnt = s.cnt + 16'h0001;
            end
         end
      end

      // Buffer transfer on update
      if (xfer) begin
         if (s.buffer_valid[0]) begin
            next_s.per = s.per_staging;
            next_s.buffer_valid[0] = 1'b0;
         end
         for (int n = 0; n < 3; n++) begin
            if (s.buffer_valid[n + 1]) begin
               next_s.cmp[n] = s.cmp_staging[n];
               next_s.buffer_valid[n + 1] = 1'b0;
            end
         end
      end

      // Software side of flags and registers; hardware sets follow so they win
      if (bus.wr) begin
         case (bus.addr)
            `TBEIC_A_CTRL_CLR: begin
               if (bus.wdata[`TBEIC_B_LOCK]) begin
                  next_s.update_lock = 1'b0;
               end
               if (bus.wdata[`TBEIC_B_DIR]) begin
                  next_s.dir = 1'b0;
               end
            end
            `TBEIC_A_CTRL_SET: begin
               if (bus.wdata[`TBEIC_B_LOCK]) begin
                  next_s.update_lock = 1'b1;
               end
               if (bus.wdata[`TBEIC_B_DIR]) begin
                  next_s.dir = 1'b1;
               end
            end
            `TBEIC_A_BV_CLR: next_s.buffer_valid = next_s.buffer_valid & ~bus.wdata[3:0];
            `TBEIC_A_BV_SET: next_s.buffer_valid = next_s.buffer_valid | bus.wdata[3:0];
            `TBEIC_A_EVCTL: begin
               next_s.event_count_enable = bus.wdata[`TBEIC_B_EV_EN];
               next_s.event_action = tbeic_event_action_t'(bus.wdata[`TBEIC_B_EV_ACT +: 2]);
            end
            `TBEIC_A_IEN: begin
               next_s.irq_enable[3:1] = bus.wdata[`TBEIC_B_CMPF +: 3];
               next_s.irq_enable[0] = bus.wdata[`TBEIC_B_WRAP];
            end
            `TBEIC_A_IFLAG: begin
               next_s.irq_flag[3:1] = s.irq_flag[3:1] & ~bus.wdata[`TBEIC_B_CMPF +: 3];
               next_s.irq_flag[0] = s.irq_flag[0] & ~bus.wdata[`TBEIC_B_WRAP];
            end
            `TBEIC_A_DBG: next_s.run_when_halted = bus.wdata[`TBEIC_B_DBG_RUN];
            `TBEIC_A_TEMP: next_s.temp = bus.wdata;
            default: begin
               if (wide && !bus.addr[0]) begin
                  next_s.temp = bus.wdata;
               end else if (wide) begin
                  case (wsel)
                     4'h0: next_s.cnt = wnew;
                     4'h1: next_s.per = wnew;
                     4'h2: next_s.cmp[0] = wnew;
                     4'h3: next_s.cmp[1] = wnew;
                     4'h4: next_s.cmp[2] = wnew;
                     4'h5: begin
                        next_s.per_staging = wnew;
                        next_s.buffer_valid[0] = 1'b1;
                     end
                     4'h6: begin
                        next_s.cmp_staging[0] = wnew;
                        next_s.buffer_valid[1] = 1'b1;
                     end
                     4'h7: begin
                        next_s.cmp_staging[1] = wnew;
                        next_s.buffer_valid[2] = 1'b1;
                     end
                     4'h8: begin
                        next_s.cmp_staging[2] = wnew;
                        next_s.buffer_valid[3] = 1'b1;
                     end
                     default: next_s.temp = s.temp;
                  endcase
               end
            end
         endcase
      end

      // Hardware flag sets
      for (int n = 0; n < 3; n++) begin
         if (step && s.cnt == s.cmp[n]) begin
            next_s.irq_flag[n + 1] = 1'b1;
         end
      end
      case (wave)
         wg_normal, wg_frequency, wg_dual_top: begin
            if (hit_top) begin
               next_s.irq_flag[0] = 1'b1;
            end
         end
         wg_dual_both: begin
            if (hit_top || hit_bot) begin
               next_s.irq_flag[0] = 1'b1;
            end
         end
         default: begin
            if (hit_bot) begin
               next_s.irq_flag[0] = 1'b1;
            end
         end
      endcase

      // Read path, one cycle after the strobe
      next_s.rdata = `TBEIC_RST_BYTE;
      if (bus.rd) begin
         case (bus.addr)
            `TBEIC_A_CTRL_CLR, `TBEIC_A_CTRL_SET: begin
               next_s.rdata[`TBEIC_B_LOCK] = s.update_lock;
               next_s.rdata[`TBEIC_B_DIR] = s.dir;
            end
            `TBEIC_A_BV_CLR, `TBEIC_A_BV_SET: next_s.rdata[3:0] = s.buffer_valid;
            `TBEIC_A_EVCTL: begin
               next_s.rdata[`TBEIC_B_EV_EN] = s.event_count_enable;
               next_s.rdata[`TBEIC_B_EV_ACT +: 2] = s.event_action;
            end
            `TBEIC_A_IEN: begin
               next_s.rdata[`TBEIC_B_CMPF +: 3] = s.irq_enable[3:1];
               next_s.rdata[`TBEIC_B_WRAP] = s.irq_enable[0];
            end
            `TBEIC_A_IFLAG: begin
               next_s.rdata[`TBEIC_B_CMPF +: 3] = s.irq_flag[3:1];
               next_s.rdata[`TBEIC_B_WRAP] = s.irq_flag[0];
            end
            `TBEIC_A_DBG: next_s.rdata[`TBEIC_B_DBG_RUN] = s.run_when_halted;
            `TBEIC_A_TEMP: next_s.rdata = s.temp;
            default: begin
               if (wide && !bus.addr[0]) begin
                  next_s.rdata = wval[7:0];
                  // A direct temp write in the same cycle keeps its byte
                  if (!(bus.wr && bus.addr == `TBEIC_A_TEMP)) begin
                     next_s.temp = wval[15:8];
                  end
               end else if (wide) begin
                  next_s.rdata = s.temp;
               end
            end
         endcase
      end
   end

   // ***********************************************
   // Registers
   // ***********************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // Period pair resets to all ones, everything else to zero
         s <= '0;
         s.per <= `TBEIC_RST_PER;
         s.per_staging <= `TBEIC_RST_PER;
      end else begin
         s <= next_s;
      end
   end

   // ***********************************************
   // Outputs
   // ***********************************************
   assign reg_rdata = s.rdata;
   // Requests are flag and enable, with no extra delay
   assign compare_irq = s.irq_flag[3:1] & s.irq_enable[3:1];
   assign wrap_irq = s.irq_flag[0] & s.irq_enable[0];
   assign counter_value = s.cnt;
   assign count_down = s.dir;

endmodule : tbeic_timer_ctrl

// ==== bench/tbeic_timer_ctrl_props.sv ====
// Port-level checks of the timer control block
// Assumes a bind onto tbeic_timer_ctrl, all inputs on clk
`timescale 1ns/1ps
module tbeic_timer_ctrl_props
   import tbeic_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire tbeic_bus_t bus,
   input wire logic [7:0] reg_rdata,
   input wire logic [2:0] waveform_select,
   input wire logic timer_enable,
   input wire logic prescale_tick,
   input wire logic event_in,
   input wire logic debug_break,
   input wire logic [2:0] compare_irq,
   input wire logic wrap_irq,
   input wire logic [15:0] counter_value,
   input wire logic count_down
);
   // **********
   // Shadows of control bits
   // **********
   logic [3:0] ien;
   logic ev_en;
   logic run;
   logic cnt_wr;
   logic step;
   assign cnt_wr = bus.wr && bus.addr[5:1] == 5'h10;
   assign step = timer_enable && !debug_break && !ev_en && prescale_tick && !cnt_wr && waveform_select == 3'h0;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ien <= 4'h0;
         ev_en <= 1'b0;
         run <= 1'b0;
      end else if (bus.wr) begin
         if (bus.addr == 6'h0a) ien <= {bus.wdata[6:4], bus.wdata[0]};
         if (bus.addr == 6'h09) ev_en <= bus.wdata[0];
         if (bus.addr == 6'h0e) run <= bus.wdata[0];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // **********
   // Properties
   // **********
   property p_rd_low;
      bus.rd && bus.addr == 6'h20 |=> reg_rdata == $past(counter_value[7:0]);
   endproperty
   a_rd_low: assert property (p_rd_low) else $error("low byte read wrong");
   property p_rd_pair;
      (bus.rd && !bus.wr && bus.addr == 6'h20) ##1 !bus.wr ##1 (bus.rd && !bus.wr && bus.addr == 6'h21)
         |=> reg_rdata == $past(counter_value[15:8], 3);
   endproperty
   a_rd_pair: assert property (p_rd_pair) else $error("high byte not latched");
   property p_cnt_high;
      bus.wr && bus.addr == 6'h21 |=> counter_value[15:8] == $past(bus.wdata);
   endproperty
   a_cnt_high: assert property (p_cnt_high) else $error("counter write lost");
   property p_count_up;
      step && !count_down |=> counter_value == $past(counter_value) + 16'h1 || counter_value == 16'h0;
   endproperty
   a_count_up: assert property (p_count_up) else $error("up count wrong");
   property p_count_down;
      step && count_down && counter_value != 16'h0 |=> counter_value == $past(counter_value) - 16'h1;
   endproperty
   a_count_down: assert property (p_count_down) else $error("down count wrong");
   property p_halt;
      debug_break && !run && !cnt_wr |=> $stable(counter_value);
   endproperty
   a_halt: assert property (p_halt) else $error("counter moved in break");
   property p_irq_mask;
      (compare_irq & ~ien[3:1]) == 3'h0 && (!wrap_irq || ien[0]);
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("request without enable");
   property p_cmp_sticky;
      !(bus.wr && bus.addr inside {6'h0a, 6'h0b}) |=> (compare_irq & $past(compare_irq)) == $past(compare_irq);
   endproperty
   a_cmp_sticky: assert property (p_cmp_sticky) else $error("compare flag dropped");
   c_step: cover property (step ##1 counter_value != 16'h0);
   c_cmp: cover property (compare_irq != 3'h0);
   c_wrap: cover property (wrap_irq);
endmodule : tbeic_timer_ctrl_props

bind tbeic_timer_ctrl tbeic_timer_ctrl_props u_props (
   .clk(clk), .rst_n(rst_n), .bus(bus), .reg_rdata(reg_rdata), .waveform_select(waveform_select),
   .timer_enable(timer_enable), .prescale_tick(prescale_tick), .event_in(event_in),
   .debug_break(debug_break), .compare_irq(compare_irq), .wrap_irq(wrap_irq),
   .counter_value(counter_value), .count_down(count_down)
);

// ==== bench/test_tbeic_timer_ctrl.sv ====
// Self-checking bench for the timer control block
// Assumes the checker binds itself from its own file
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module test_tbeic_timer_ctrl
   import tbeic_pkg::*;
;
   tbeic_bus_t bus;
   logic [7:0] reg_rdata;
   logic [2:0] compare_irq;
   logic [2:0] waveform_select;
   logic [15:0] counter_value;
   logic clk, rst_n, timer_enable, prescale_tick, event_in, debug_break, wrap_irq, count_down;
   logic [5:0] rst_addrs [10] = '{6'h06, 6'h07, 6'h09, 6'h0a, 6'h0b, 6'h0e, 6'h0f, 6'h20, 6'h21, 6'h3f};
   int miscompares = 0;
   int cmp_count = 0;
   int cycles = 0;

   tbeic_timer_ctrl u_tbeic_timer_ctrl (
      .clk(clk), .rst_n(rst_n), .bus(bus), .reg_rdata(reg_rdata), .waveform_select(waveform_select),
      .timer_enable(timer_enable), .prescale_tick(prescale_tick), .event_in(event_in),
      .debug_break(debug_break), .compare_irq(compare_irq), .wrap_irq(wrap_irq),
      .counter_value(counter_value), .count_down(count_down)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // **********
   // Bus and stimulus tasks
   // **********
   task automatic wr(input logic [5:0] a, input logic [7:0] v, input logic t = 1'b0);
      bus.wr = 1'b1;
      bus.addr = a;
      bus.wdata = v;
      prescale_tick = t;
      @(posedge clk);
      #1;
      bus.wr = 1'b0;
      prescale_tick = 1'b0;
      @(posedge clk);
      #1;
   endtask : wr

   task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
      bus.rd = 1'b1;
      bus.addr = a;
      @(posedge clk);
      #1;
      bus.rd = 1'b0;
      `CHK(reg_rdata, e)
      @(posedge clk);
      #1;
   endtask : rdchk

   task automatic tick(input int n);
      repeat (n) begin
         prescale_tick = 1'b1;
         @(posedge clk);
         #1;
         prescale_tick = 1'b0;
         @(posedge clk);
         #1;
      end
   endtask : tick

   task automatic evt(input int n);
      repeat (n) begin
         event_in = ~event_in;
         repeat (2) @(posedge clk);
         #1;
      end
   endtask : evt

   task automatic test_done;
      $display("Counts: compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : test_done

   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         test_done;
      end
   end

   initial begin
      bus = '0;
      waveform_select = 3'h0;
      rst_n = 1'b0;
      timer_enable = 1'b1;
      prescale_tick = 1'b0;
      event_in = 1'b0;
      debug_break = 1'b0;
      repeat (10) @(posedge clk);
      #1;
      rst_n = 1'b1;
      foreach (rst_addrs[i]) rdchk(rst_addrs[i], 8'h00);
      $display("Test reset done");
      wr(6'h07, 8'hff);
      rdchk(6'h06, 8'h0f);
      rdchk(6'h07, 8'h0f);
      wr(6'h06, 8'h05);
      rdchk(6'h07, 8'h0a);
      wr(6'h06, 8'h00);
      rdchk(6'h06, 8'h0a);
      wr(6'h06, 8'h0f);
      wr(6'h3a, 8'h34);
      wr(6'h3b, 8'h12);
      rdchk(6'h06, 8'h04);
      wr(6'h36, 8'h00);
      wr(6'h37, 8'h01);
      rdchk(6'h06, 8'h05);
      wr(6'h05, 8'h02);
      wr(6'h05, 8'h04);
      rdchk(6'h06, 8'h05);
      rdchk(6'h2a, 8'h00);
      wr(6'h04, 8'h02);
      wr(6'h05, 8'h04);
      rdchk(6'h06, 8'h00);
      rdchk(6'h2a, 8'h34);
      rdchk(6'h2b, 8'h12);
      rdchk(6'h26, 8'h00);
      rdchk(6'h27, 8'h01);
      $display("Test buffers done");
      wr(6'h20, 8'hcd);
      rdchk(6'h0f, 8'hcd);
      wr(6'h21, 8'hab);
      `CHK(counter_value, 16'habcd);
      rdchk(6'h20, 8'hcd);
      rdchk(6'h21, 8'hab);
      wr(6'h0f, 8'h5a);
      rdchk(6'h0f, 8'h5a);
      wr(6'h20, 8'h10);
      wr(6'h21, 8'h00, 1'b1);
      `CHK(counter_value, 16'h0010);
      $display("Test wide access done");
      tick(5);
      `CHK(counter_value, 16'h0015);
      wr(6'h05, 8'h01);
      rdchk(6'h04, 8'h01);
      tick(5);
      `CHK(counter_value, 16'h0010);
      wr(6'h04, 8'h01);
      $display("Test direction done");
      wr(6'h09, 8'h01);
      evt(6);
      `CHK(counter_value, 16'h0013);
      tick(2);
      `CHK(counter_value, 16'h0013);
      wr(6'h09, 8'h03);
      evt(4);
      `CHK(counter_value, 16'h0017);
      wr(6'h09, 8'h05);
      event_in = 1'b1;
      tick(4);
      event_in = 1'b0;
      tick(4);
      `CHK(counter_value, 16'h001b);
      wr(6'h09, 8'h07);
      tick(3);
      event_in = 1'b1;
      tick(3);
      event_in = 1'b0;
      `CHK(counter_value, 16'h001b);
      wr(6'h09, 8'h06);
      wr(6'h04, 8'h01);
      evt(2);
      tick(2);
      `CHK(counter_value, 16'h001d);
      $display("Test events done");
      debug_break = 1'b1;
      tick(3);
      `CHK(counter_value, 16'h001d);
      wr(6'h0e, 8'h01);
      tick(3);
      `CHK(counter_value, 16'h0020);
      debug_break = 1'b0;
      wr(6'h0e, 8'h00);
      $display("Test debug done");
      wr(6'h0b, 8'hff);
      wr(6'h20, 8'h40);
      wr(6'h21, 8'h00);
      wr(6'h38, 8'h42);
      wr(6'h39, 8'h00);
      wr(6'h05, 8'h04);
      wr(6'h0a, 8'h11);
      tick(2);
      rdchk(6'h0b, 8'h00);
      tick(1);
      rdchk(6'h0b, 8'h10);
      `CHK(compare_irq, 3'b001);
      tick(2);
      rdchk(6'h0b, 8'h10);
      wr(6'h0b, 8'h10);
      rdchk(6'h0b, 8'h00);
      wr(6'h20, 8'h00);
      wr(6'h21, 8'h01);
      tick(1);
      `CHK(counter_value, 16'h0000);
      rdchk(6'h0b, 8'h01);
      `CHK(wrap_irq, 1'b1);
      wr(6'h0a, 8'h10);
      `CHK(wrap_irq, 1'b0);
      wr(6'h0b, 8'h01);
      rdchk(6'h0b, 8'h00);
      $display("Test interrupts done");
      waveform_select = 3'h6;
      wr(6'h20, 8'hff);
      wr(6'h21, 8'h00);
      tick(2);
      `CHK(counter_value, 16'h00ff);
      `CHK(count_down, 1'b1);
      rdchk(6'h0b, 8'h01);
      $display("Test dual slope done");
      test_done;
   end
endmodule : test_tbeic_timer_ctrl
